/* File: src/key_report_encoder.sv */
// Registered encoder for summary and per-key report bytes
`timescale 1ns/100ps
module key_report_encoder (
  input wire logic i_core_clk,
  input wire logic i_rst,
  key_status_if.enc ks
);
  logic [2:0] err_or;
  // ==========================================
  // OR of all key error flags
  always_comb begin
    err_or = 3'b000;
    for (int k = 0; k < touch_key_pkg::NUM_KEYS; k++) begin
      err_or = err_or | ks.err[k];
    end
  end
  // Summary and all-keys bytes
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ks.summary <= 8'h00;
      ks.all_report <= 8'h00;
    end else begin
      ks.summary <= {2'b00, ks.touched};
      ks.all_report <= {1'b0, 4'h0, err_or};
    end
  end
  // One byte per key, in key order; touched flag on top, flags below
  genvar g;
  generate
    for (g = 0; g < touch_key_pkg::NUM_KEYS; g++) begin : g_key
      always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
          ks.key_report[g] <= 8'h00;
        end else begin
          ks.key_report[g] <= {ks.touched[g], 4'h0, ks.err[g]};
        end
      end
    end
  endgenerate
  touched_bit_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    ks.key_report[0][7] == $past(ks.touched[0]) || $past(i_rst))
    else $error("report touched bit wrong");
  all_zero_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    ks.all_report[7:3] == 5'h00)
    else $error("all-keys report top bits set");
  err_or_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !$past(i_rst) |-> ks.all_report[2:0] == $past(err_or))
    else $error("all-keys error OR wrong");
  summary_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !$past(i_rst) |-> ks.summary == {2'b00, $past(ks.touched)})
    else $error("summary byte wrong");
endmodule : key_report_encoder

/* File: src/key_status_if.sv */
// Interface carrying per-key status between the report encoder and the top
`timescale 1ns/100ps
interface key_status_if;
  logic [touch_key_pkg::NUM_KEYS-1:0] touched;
  logic [2:0] err [touch_key_pkg::NUM_KEYS];
  logic [7:0] summary;
  logic [7:0] all_report;
  logic [7:0] key_report [touch_key_pkg::NUM_KEYS];
  modport src (input summary, input all_report, input key_report, output touched, output err);
  modport enc (output summary, output all_report, output key_report, input touched, input err);
endinterface : key_status_if

/* File: src/sleep_controller.sv */
// Low-power and deep sleep controller with bus wake
`timescale 1ns/100ps
module sleep_controller #(
  parameter int SLEEP_UNIT = touch_key_pkg::SLEEP_UNIT_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_cfg,
  input wire logic i_cfg_wr,
  input wire logic i_any_detect,
  input wire logic i_bus_activity,
  input wire logic i_addr_match,
  output logic o_nack_addr,
  output logic o_low_power_on,
  output logic o_sleeping,
  output logic o_deep_sleep
);
  touch_key_pkg::pwr_state_t state_reg;
  logic [31:0] unit_cnt_reg;
  logic [5:0] tick_cnt_reg;
  logic [5:0] sf;
  logic lp_en;
  logic paused;
  assign sf = i_cfg[5:0];
  // ==========================================
  // Factor decode: 0x01..0x19 enables, deep handled separately
  assign lp_en = (sf != touch_key_pkg::SF_OFF) && (sf <= touch_key_pkg::SF_MAX_SLEEP);
  assign paused = i_cfg[touch_key_pkg::FREERUN_BIT] && i_any_detect;
  assign o_low_power_on = lp_en && !paused;
  assign o_sleeping = state_reg != touch_key_pkg::PWR_RUN;
  assign o_deep_sleep = state_reg == touch_key_pkg::PWR_DEEP;
  // Wake by address is not acknowledged; master must resend
  assign o_nack_addr = o_sleeping && i_addr_match;
  // Power state machine
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_reg <= touch_key_pkg::PWR_RUN;
    end else begin
      unique case (state_reg)
        touch_key_pkg::PWR_RUN: begin
          if (i_cfg_wr && sf == touch_key_pkg::SF_DEEP) begin
            state_reg <= touch_key_pkg::PWR_DEEP;
          end else if (o_low_power_on && unit_cnt_reg == 32'(SLEEP_UNIT - 1)) begin
            state_reg <= touch_key_pkg::PWR_SLEEP;
          end
        end
        touch_key_pkg::PWR_SLEEP: begin
          if (i_bus_activity || !o_low_power_on ||
              (unit_cnt_reg == 32'(SLEEP_UNIT - 1) && tick_cnt_reg + 6'd1 >= sf)) begin
            state_reg <= touch_key_pkg::PWR_RUN;
          end
        end
        touch_key_pkg::PWR_DEEP: begin
          if (i_addr_match) begin
            state_reg <= touch_key_pkg::PWR_RUN;
          end
        end
        default: state_reg <= touch_key_pkg::PWR_RUN;
      endcase
    end
  end
  // Sleep period counters: unit of 20 ms times factor
  always_ff @(posedge i_core_clk) begin
    if (i_rst || state_reg == touch_key_pkg::PWR_DEEP) begin
      unit_cnt_reg <= 32'h0000_0000;
      tick_cnt_reg <= 6'h00;
    end else if (unit_cnt_reg == 32'(SLEEP_UNIT - 1)) begin
      unit_cnt_reg <= 32'h0000_0000;
      tick_cnt_reg <= (state_reg == touch_key_pkg::PWR_SLEEP) ? tick_cnt_reg + 6'd1 : 6'h00;
    end else begin
      unit_cnt_reg <= unit_cnt_reg + 32'd1;
    end
  end
  deep_enter_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_reg == touch_key_pkg::PWR_RUN && i_cfg_wr && sf == touch_key_pkg::SF_DEEP)
    |=> o_deep_sleep)
    else $error("deep sleep not entered");
  deep_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_deep_sleep && !i_addr_match) |=> o_deep_sleep)
    else $error("deep sleep left without address");
  wake_bus_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_reg == touch_key_pkg::PWR_SLEEP && i_bus_activity) |=> !o_sleeping)
    else $error("no wake on bus activity");
  lp_off_a: assert property (@(posedge i_core_clk)
    (sf == 6'h00 || (sf >= 6'h20 && sf <= 6'h3E)) |-> !o_low_power_on)
    else $error("low power enabled by bad factor");
  nack_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_deep_sleep && i_addr_match) |-> o_nack_addr ##1 !o_sleeping)
    else $error("wake address handling wrong");
  deep_c: cover property (@(posedge i_core_clk) o_deep_sleep ##1 !o_sleeping);
  sleep_c: cover property (@(posedge i_core_clk) state_reg == touch_key_pkg::PWR_SLEEP);
endmodule : sleep_controller

/* File: src/touch_key_pkg.sv */
// Constants and types shared by the touch key report encoding block
// ==========================================
package touch_key_pkg;
  localparam int NUM_KEYS = 6;  // Keys 1..5 plus rotor/slider
  localparam int NUM_GROUPS = 8;
  localparam logic [7:0] ERR_NONE = 8'h01;
  localparam logic [7:0] ERR_BAD_PARAM = 8'h85;
  localparam int TOUCH_BIT = 7;
  localparam int ENABLE_BIT = 7;
  localparam int FREQ_BIT = 7;
  localparam int FREERUN_BIT = 6;
  localparam int ROTOR_IDX = 5;
  localparam logic [3:0] ID_ALL = 4'h0;
  localparam logic [3:0] ID_KEY5 = 4'h5;
  localparam logic [3:0] ID_ROTOR = 4'h7;
  localparam logic [5:0] SF_OFF = 6'h00;
  localparam logic [5:0] SF_MAX_SLEEP = 6'h19;
  localparam logic [5:0] SF_DEEP = 6'h3F;
  localparam logic [7:0] DBG_CALIB = 8'h01;
  localparam logic [7:0] DBG_RELEASED = 8'h02;
  localparam logic [7:0] DBG_TOUCHED = 8'h04;
  localparam logic [7:0] DBG_ERROR = 8'h08;
  localparam logic [7:0] DBG_RECAL_FILT = 8'h11;
  localparam logic [7:0] DBG_DETECT_FILT = 8'h14;
  localparam logic [7:0] DBG_RELEASE_FILT = 8'h24;
  localparam logic [7:0] RST_SLEEP_CFG = 8'h00;
  localparam logic [NUM_KEYS-1:0] RST_KEY_EN = 6'h3F;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SLEEP_UNIT_MS = 20;
  localparam int SLEEP_UNIT_CYC = SLEEP_UNIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SLEEP_CNT_W = 32;
  typedef enum logic [2:0] {
    PWR_RUN = 3'b001,
    PWR_SLEEP = 3'b010,
    PWR_DEEP = 3'b100
  } pwr_state_t;
endpackage : touch_key_pkg

/* File: src/touch_key_report_encoding.sv */
// Top: key enable decode, suppression, outputs, debug codes and reports
`timescale 1ns/100ps
module touch_key_report_encoding #(
  parameter int SLEEP_UNIT = touch_key_pkg::SLEEP_UNIT_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [5:0] i_key_detect,
  input wire logic [5:0] i_key_calibrating,
  input wire logic [5:0] i_key_max_count,
  input wire logic [5:0] i_key_min_missed,
  input wire logic [47:0] i_key_signal,
  input wire logic [5:0] i_recal_fired,
  input wire logic [5:0] i_detect_fired,
  input wire logic [5:0] i_release_fired,
  input wire logic [7:0] i_key_enable_select_byte,
  input wire logic i_key_enable_wr,
  input wire logic [7:0] i_sleep_config_byte,
  input wire logic i_sleep_config_wr,
  input wire logic [7:0] i_output_pin_levels,
  input wire logic i_output_wr,
  input wire logic [7:0] i_suppression_group_modes,
  input wire logic [47:0] i_suppression_membership,
  input wire logic i_bus_activity,
  input wire logic i_addr_match,
  output logic [7:0] o_touched_summary_byte,
  output logic [7:0] o_all_keys_report,
  output logic [47:0] o_per_key_report_byte,
  output logic [47:0] o_key_debug_code,
  output logic [7:0] o_enable_status,
  output logic [5:0] o_key_enabled,
  output logic [5:0] o_recal_request,
  output logic [4:0] o_gpo,
  output logic o_max_frequency,
  output logic o_low_power_on,
  output logic o_sleeping,
  output logic o_deep_sleep,
  output logic o_nack_addr
);
  localparam int NK = touch_key_pkg::NUM_KEYS;
  key_status_if ks ();
  logic [NK-1:0] key_en_reg;
  logic [NK-1:0] recal_reg;
  logic [7:0] status_reg;
  logic [7:0] sleep_cfg_reg;
  logic sleep_wr_reg;
  logic [4:0] gpo_reg;
  logic [NK-1:0] touched_reg;
  logic [NK-1:0] touched_next;
  logic [NK-1:0] sel_mask;
  logic id_ok;
  logic sel_ok;

  // ==========================================
  // Key identifier decode, used for validity and selection
  function automatic logic [NK:0] decode_id(input logic [3:0] id);
    logic [NK:0] r;
    r = '0;
    if (id == touch_key_pkg::ID_ALL) begin
      r = {1'b1, {NK{1'b1}}};
    end else if (id >= 4'h1 && id <= touch_key_pkg::ID_KEY5) begin
      r = {1'b1, 6'(6'b1 << (id - 4'h1))};
    end else if (id == touch_key_pkg::ID_ROTOR) begin
      r = {1'b1, 6'(6'b1 << touch_key_pkg::ROTOR_IDX)};
    end
    return r;
  endfunction : decode_id

  // Decoded key mask and validity of the key identifier
  assign {id_ok, sel_mask} = decode_id(i_key_enable_select_byte[3:0]);
  // Accepted select byte: known id and reserved bits clear
  assign sel_ok = id_ok && (i_key_enable_select_byte[6:4] == 3'b000);

  // ==========================================
  // Key enables; a bad id or nonzero reserved bits is refused
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      key_en_reg <= touch_key_pkg::RST_KEY_EN;
      status_reg <= touch_key_pkg::ERR_NONE;
    end else if (i_key_enable_wr) begin
      if (sel_ok) begin
        status_reg <= touch_key_pkg::ERR_NONE;
        if (i_key_enable_select_byte[touch_key_pkg::ENABLE_BIT]) begin
          key_en_reg <= key_en_reg | sel_mask;
        end else begin
          key_en_reg <= key_en_reg & ~sel_mask;
        end
      end else begin
        status_reg <= touch_key_pkg::ERR_BAD_PARAM;
      end
    end
  end

  // Recalibration pulse for every enabled key after an accepted change
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      recal_reg <= '0;
    end else begin
      recal_reg <= '0;
      if (i_key_enable_wr && sel_ok) begin
        if (i_key_enable_select_byte[touch_key_pkg::ENABLE_BIT]) begin
          recal_reg <= key_en_reg | sel_mask;
        end else begin
          recal_reg <= key_en_reg & ~sel_mask;
        end
      end
    end
  end

  // ==========================================
  // Sleep configuration; bit 7 picks frequency, default reduced
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sleep_cfg_reg <= touch_key_pkg::RST_SLEEP_CFG;
      sleep_wr_reg <= 1'b0;
    end else begin
      sleep_wr_reg <= i_sleep_config_wr;
      if (i_sleep_config_wr) begin
        sleep_cfg_reg <= i_sleep_config_byte;
      end
    end
  end
  assign o_max_frequency = sleep_cfg_reg[touch_key_pkg::FREQ_BIT];

  // General purpose outputs follow their bits; high bits ignored
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      gpo_reg <= 5'h00;
    end else if (i_output_wr) begin
      gpo_reg <= i_output_pin_levels[4:0];
    end
  end
  assign o_gpo = gpo_reg;

  // ==========================================
  // Adjacent suppression: per group, locking holds first winner,
  // unlocking takes the strongest signal. A key reports touched only
  // if it wins every group it belongs to.
  // A locking group whose holder lets go blocks all members for one cycle;
  // the next cycle picks afresh, so no extra history has to be kept.
  always_comb begin
    logic [NK-1:0] ok;
    logic [NK-1:0] held;
    logic [7:0] best;
    logic [NK-1:0] win;
    held = '0;
    best = 8'h00;
    win = '0;
    ok = i_key_detect & key_en_reg;
    for (int g = 0; g < touch_key_pkg::NUM_GROUPS; g++) begin
      held = '0;
      for (int k = 0; k < NK; k++) begin
        if (i_suppression_membership[k*8+g] && touched_reg[k]) begin
          held[k] = 1'b1;
        end
      end
      win = '0;
      if (!i_suppression_group_modes[g] && held != '0) begin
        win = held & ok;
        if (win == '0) begin
          win = '0;
        end
      end else begin
        best = 8'h00;
        for (int k = 0; k < NK; k++) begin
          if (i_suppression_membership[k*8+g] && ok[k] && win == '0) begin
            win[k] = 1'b1;
            best = i_key_signal[k*8 +: 8];
          end else if (i_suppression_membership[k*8+g] && ok[k] &&
                       i_key_signal[k*8 +: 8] > best) begin
            win = '0;
            win[k] = 1'b1;
            best = i_key_signal[k*8 +: 8];
          end
        end
      end
      for (int k = 0; k < NK; k++) begin
        if (i_suppression_membership[k*8+g] && !win[k]) begin
          ok[k] = 1'b0;
        end
      end
    end
    touched_next = ok;
  end

  // Registered touched state after suppression
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      touched_reg <= '0;
    end else begin
      touched_reg <= touched_next;
    end
  end

  // ==========================================
  // Status towards the encoder
  assign ks.touched = touched_reg;
  genvar gk;
  generate
    for (gk = 0; gk < NK; gk++) begin : g_err
      assign ks.err[gk] = {i_key_min_missed[gk], i_key_max_count[gk],
                           i_key_calibrating[gk]};
      assign o_per_key_report_byte[gk*8 +: 8] = ks.key_report[gk];
      // Debug code: error state first, then filter events, then the other steady states
      always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
          o_key_debug_code[gk*8 +: 8] <= touch_key_pkg::DBG_RELEASED;
        end else if (i_key_min_missed[gk] || i_key_max_count[gk]) begin
          o_key_debug_code[gk*8 +: 8] <= touch_key_pkg::DBG_ERROR;
        end else if (i_recal_fired[gk]) begin
          o_key_debug_code[gk*8 +: 8] <= touch_key_pkg::DBG_RECAL_FILT;
        end else if (i_detect_fired[gk]) begin
          o_key_debug_code[gk*8 +: 8] <= touch_key_pkg::DBG_DETECT_FILT;
        end else if (i_release_fired[gk]) begin
          o_key_debug_code[gk*8 +: 8] <= touch_key_pkg::DBG_RELEASE_FILT;
        end else if (i_key_calibrating[gk] || recal_reg[gk]) begin
          o_key_debug_code[gk*8 +: 8] <= touch_key_pkg::DBG_CALIB;
        end else if (touched_reg[gk]) begin
          o_key_debug_code[gk*8 +: 8] <= touch_key_pkg::DBG_TOUCHED;
        end else begin
          o_key_debug_code[gk*8 +: 8] <= touch_key_pkg::DBG_RELEASED;
        end
      end
    end
  endgenerate

  key_report_encoder u_enc (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .ks(ks)
  );

  sleep_controller #(.SLEEP_UNIT(SLEEP_UNIT)) u_sleep (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_cfg(sleep_cfg_reg),
    .i_cfg_wr(sleep_wr_reg),
    .i_any_detect(|(i_key_detect & key_en_reg)),
    .i_bus_activity(i_bus_activity),
    .i_addr_match(i_addr_match),
    .o_nack_addr(o_nack_addr),
    .o_low_power_on(o_low_power_on),
    .o_sleeping(o_sleeping),
    .o_deep_sleep(o_deep_sleep)
  );

  assign o_touched_summary_byte = ks.summary;
  assign o_all_keys_report = ks.all_report;
  assign o_enable_status = status_reg;
  assign o_key_enabled = key_en_reg;
  assign o_recal_request = recal_reg;

  // ==========================================
  // Checks
  recal_all_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_recal_request != '0 |-> o_recal_request == key_en_reg)
    else $error("recalibration set differs from enabled keys");
  bad_id_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_key_enable_wr && !id_ok) |=> status_reg == touch_key_pkg::ERR_BAD_PARAM
      && key_en_reg == $past(key_en_reg))
    else $error("bad key id not refused");
  gpo_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_output_wr |=> o_gpo == $past(i_output_pin_levels[4:0]))
    else $error("output pins not updated");
  lock_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (touched_reg[0] && touched_reg[1]) |-> !(i_suppression_membership[0]
      && i_suppression_membership[8] && !i_suppression_group_modes[0]
      && $past(touched_reg[0]) && !$past(touched_reg[1])))
    else $error("locking group let second key in");
  enable_c: cover property (@(posedge i_core_clk) i_key_enable_wr ##1 o_recal_request != '0);
  bad_c: cover property (@(posedge i_core_clk) status_reg == touch_key_pkg::ERR_BAD_PARAM);
  touch_c: cover property (@(posedge i_core_clk) o_touched_summary_byte != 8'h00);

  // Refusal, enable, output and suppression checks on what the logic drives
  rsvd_refuse_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_key_enable_wr && i_key_enable_select_byte[6:4] != 3'b000) |=>
      status_reg == touch_key_pkg::ERR_BAD_PARAM && $stable(key_en_reg))
    else $error("reserved select bits not refused");
  enable_set_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_key_enable_wr && sel_ok && i_key_enable_select_byte[touch_key_pkg::ENABLE_BIT]) |=>
      (key_en_reg & $past(sel_mask)) == $past(sel_mask))
    else $error("selected key not enabled");
  disable_clr_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_key_enable_wr && sel_ok && !i_key_enable_select_byte[touch_key_pkg::ENABLE_BIT]) |=>
      (key_en_reg & $past(sel_mask)) == '0)
    else $error("selected key not disabled");
  freq_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_sleep_config_wr |=>
      o_max_frequency == $past(i_sleep_config_byte[touch_key_pkg::FREQ_BIT]))
    else $error("frequency select not taken");
  recal_zero_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !$past(i_key_enable_wr) |-> o_recal_request == '0)
    else $error("recalibration without enable change");
  gpo_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_output_wr |=> $stable(o_gpo))
    else $error("output pins changed without write");
  touch_gate_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (touched_reg & ~$past(i_key_detect & key_en_reg)) == '0)
    else $error("touched key not detected and enabled");
  unlock_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_suppression_group_modes[0] && i_suppression_membership[0]
      && i_suppression_membership[8]
      && (i_key_detect[1:0] & key_en_reg[1:0]) == 2'b11
      && i_key_signal[15:8] > i_key_signal[7:0]) |=> !touched_reg[0])
    else $error("weaker key won an unlocking group");
  dbg_error_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_key_min_missed[2] || i_key_max_count[2]) |=>
      o_key_debug_code[23:16] == touch_key_pkg::DBG_ERROR)
    else $error("error debug code not shown");
endmodule : touch_key_report_encoding

/* File: verif/host_model.sv */
// Host model: writes command bytes and wakes the device over the bus
`timescale 1ns/100ps
module host_model (
  input wire logic i_core_clk,
  input wire logic i_nack_addr,
  output logic [7:0] o_byte,
  output logic [2:0] o_wr,
  output logic o_bus_activity,
  output logic o_addr_match,
  output logic o_nack_seen
);
  // ==========================================
  // Bus idle at start
  initial begin
    o_byte = 8'h00;
    o_wr = 3'b000;
    o_bus_activity = 1'b0;
    o_addr_match = 1'b0;
    o_nack_seen = 1'b0;
  end
  // One command byte; sel 0 enable, 1 sleep config, 2 outputs
  task automatic send(input int sel, input logic [7:0] b);
    @(negedge i_core_clk);
    o_byte = b;
    o_wr[sel] = 1'b1;
    @(negedge i_core_clk);
    o_wr = 3'b000;
    o_byte = ~b; // Stale byte must not look valid
  endtask : send
  // Bus traffic not meant for this device
  task automatic activity();
    @(negedge i_core_clk);
    o_bus_activity = 1'b1;
    @(negedge i_core_clk);
    o_bus_activity = 1'b0;
  endtask : activity
  // Address wakes a sleeper but is refused, so the command goes again
  task automatic wake_and_send(input int sel, input logic [7:0] b);
    @(negedge i_core_clk);
    o_bus_activity = 1'b1;
    o_addr_match = 1'b1;
    #1;
    o_nack_seen = i_nack_addr;
    @(negedge i_core_clk);
    o_bus_activity = 1'b0;
    o_addr_match = 1'b0;
    send(sel, b);
  endtask : wake_and_send
endmodule : host_model

/* File: verif/testbench.sv */
// Self-checking bench for the touch key report encoding block
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] det = '0, cal = '0, maxc = '0, minm = '0, rcf = '0, dtf = '0, rlf = '0;
  logic [47:0] sig = '0, memb = '0, pkr, dbg;
  logic [7:0] modes = '0, byte_w, summ, allr, ens;
  logic [2:0] wr;
  logic [5:0] en, recal;
  logic [4:0] gpo;
  logic act, amatch, nack, nack_seen, maxf, lp, slp, deep;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  // ==========================================
  // Clock and parts
  always #4 clk = ~clk;
  touch_key_report_encoding #(.SLEEP_UNIT(10)) i_dut (
    .i_core_clk(clk), .i_rst(rst), .i_key_detect(det), .i_key_calibrating(cal),
    .i_key_max_count(maxc), .i_key_min_missed(minm), .i_key_signal(sig),
    .i_recal_fired(rcf), .i_detect_fired(dtf), .i_release_fired(rlf),
    .i_key_enable_select_byte(byte_w), .i_key_enable_wr(wr[0]),
    .i_sleep_config_byte(byte_w), .i_sleep_config_wr(wr[1]),
    .i_output_pin_levels(byte_w), .i_output_wr(wr[2]),
    .i_suppression_group_modes(modes), .i_suppression_membership(memb),
    .i_bus_activity(act), .i_addr_match(amatch), .o_touched_summary_byte(summ),
    .o_all_keys_report(allr), .o_per_key_report_byte(pkr), .o_key_debug_code(dbg),
    .o_enable_status(ens), .o_key_enabled(en), .o_recal_request(recal), .o_gpo(gpo),
    .o_max_frequency(maxf), .o_low_power_on(lp), .o_sleeping(slp), .o_deep_sleep(deep),
    .o_nack_addr(nack));
  host_model i_host (.i_core_clk(clk), .i_nack_addr(nack), .o_byte(byte_w), .o_wr(wr),
    .o_bus_activity(act), .o_addr_match(amatch), .o_nack_seen(nack_seen));
  // ==========================================
  // Compare and closing report
  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      final_report();
    end
  end
  // ==========================================
  // Test sequence
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    chk("enabled", 48'(6'h3F), 48'(en));
    chk("status", 48'(8'h01), 48'(ens));
    chk("debug", 48'h0202_0202_0202, dbg);
    $display("test reset done");
    det = 6'h25;
    cal = 6'h01;
    maxc = 6'h04;
    minm = 6'h10;
    repeat (3) @(negedge clk);
    chk("summary", 48'(8'h25), 48'(summ));
    chk("all_report", 48'(8'h07), 48'(allr));
    chk("per_key", 48'h8004_0082_0081, pkr);
    $display("test reports done");
    det = 6'h20;
    cal = 6'h08;
    maxc = 6'h10;
    minm = 6'h00;
    rcf = 6'h01;
    dtf = 6'h02;
    rlf = 6'h04;
    repeat (3) @(negedge clk);
    chk("debug", 48'h0408_0124_1411, dbg);
    det = 6'h00;
    cal = 6'h00;
    maxc = 6'h00;
    rcf = 6'h00;
    dtf = 6'h00;
    rlf = 6'h00;
    $display("test debug done");
    for (int i = 0; i < 6; i++) begin
      i_host.send(0, (i == 5) ? 8'h07 : 8'(i + 1));
      chk("enabled", 48'(6'h3F & ~(6'h01 << i)), 48'(en));
      chk("recal", 48'(6'h3F & ~(6'h01 << i)), 48'(recal));
      i_host.send(0, 8'h80);
    end
    i_host.send(0, 8'h00);
    chk("enabled", 48'(6'h00), 48'(en));
    i_host.send(0, 8'h06);
    chk("status", 48'(8'h85), 48'(ens));
    i_host.send(0, 8'h93);
    chk("status", 48'(8'h85), 48'(ens));
    chk("enabled", 48'(6'h00), 48'(en));
    i_host.send(0, 8'h80);
    chk("enabled", 48'(6'h3F), 48'(en));
    chk("status", 48'(8'h01), 48'(ens));
    $display("test enable done");
    i_host.send(2, 8'h15);
    chk("gpo", 48'(5'h15), 48'(gpo));
    i_host.send(2, 8'h0A);
    chk("gpo", 48'(5'h0A), 48'(gpo));
    $display("test outputs done");
    i_host.send(1, 8'h80);
    chk("max_freq", 48'(1'b1), 48'(maxf));
    chk("low_power", 48'(1'b0), 48'(lp));
    i_host.send(1, 8'h3E);
    chk("max_freq", 48'(1'b0), 48'(maxf));
    chk("low_power", 48'(1'b0), 48'(lp));
    i_host.send(1, 8'h20);
    chk("low_power", 48'(1'b0), 48'(lp));
    i_host.send(1, 8'h19);
    chk("low_power", 48'(1'b1), 48'(lp));
    i_host.send(1, 8'h02);
    repeat (14) @(negedge clk);
    chk("sleeping", 48'(1'b1), 48'(slp));
    i_host.activity();
    chk("sleeping", 48'(1'b0), 48'(slp));
    det = 6'h01;
    i_host.send(1, 8'h42);
    repeat (2) @(negedge clk);
    chk("low_power", 48'(1'b0), 48'(lp));
    det = 6'h00;
    repeat (3) @(negedge clk);
    chk("low_power", 48'(1'b1), 48'(lp));
    i_host.send(1, 8'h3F);
    repeat (2) @(negedge clk);
    chk("deep", 48'(1'b1), 48'(deep));
    i_host.wake_and_send(1, 8'h00);
    chk("nack", 48'(1'b1), 48'(nack_seen));
    chk("deep", 48'(1'b0), 48'(deep));
    chk("low_power", 48'(1'b0), 48'(lp));
    $display("test sleep done");
    modes = 8'h01;
    memb = 48'h0000_8080_0101;
    sig = 48'h0000_0000_4010;
    det = 6'h07;
    repeat (3) @(negedge clk);
    det = 6'h0F;
    repeat (3) @(negedge clk);
    chk("summary", 48'(8'h06), 48'(summ));
    // Locking group: the first key holds it even against a stronger one
    modes = 8'h00;
    det = 6'h01;
    repeat (3) @(negedge clk);
    det = 6'h03;
    repeat (3) @(negedge clk);
    chk("summary", 48'(8'h01), 48'(summ));
    $display("test suppression done");
    final_report();
  end
endmodule : testbench
